//--- logic/nvm_access_pkg.sv
// Purpose: constants for the nonvolatile access control block
// Assumes: 8-bit control register on a plain register port
// Notes: timing figures are plain defaults, shortened by parameters
package nvm_access_pkg;
  localparam int unsigned addr_width = 2; // register port address width
  localparam logic [1:0] ctrl_offset = 2'h0; // control register
  localparam logic [1:0] stat_offset = 2'h1; // status register
  localparam int unsigned space_bit = 7; // program flash / eeprom select
  localparam int unsigned config_bit = 6; // configuration space select
  localparam int unsigned unused_bit = 5; // reads zero
  localparam int unsigned erase_bit = 4; // row erase enable
  localparam int unsigned error_bit = 3; // write error flag
  localparam int unsigned permit_bit = 2; // write permit gate
  localparam int unsigned write_bit = 1; // write trigger
  localparam int unsigned read_bit = 0; // read trigger
  localparam logic [7:0] ctrl_reset = 8'h00; // power-on value
  localparam int unsigned clk_mhz = 25; // device clock rate
  localparam int unsigned write_time_us = 4000; // self-timed cycle, default
  localparam int unsigned write_cycles_dflt = write_time_us * clk_mhz; // cycles
  localparam int unsigned count_width = 24; // timer width
  localparam logic [count_width-1:0] count_one = 24'h000001; // timer step
  localparam logic [7:0] zero_byte = 8'h00; // empty read data
  typedef enum logic [1:0] {st_idle, st_write, st_erase} op_state_type;
endpackage

//--- logic/nvm_access_control.sv
// Purpose: control and status of nonvolatile read, write and row erase
// Assumes: arrays behind the block follow o_mem_*; cycle length is self-timed here
// Notes: register 1 is a read-only status view of the sequencer
`timescale 1ns/1ps
module nvm_access_control
  import nvm_access_pkg::*;
#(
  parameter int unsigned write_cycles = write_cycles_dflt // self-timed length
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [addr_width-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_abort,
  output logic [7:0] o_rdata,
  output logic o_mem_read,
  output logic o_mem_write,
  output logic o_mem_erase,
  output logic o_mem_flash,
  output logic o_mem_config
);

  localparam logic [count_width-1:0] write_last = count_width'(write_cycles - 1); // final count

  // whole module state
  typedef struct packed {
    logic space_sel; // flash when set
    logic config_sel; // configuration when set
    logic erase_en; // row erase on next trigger
    logic error_flag; // interrupted or unpermitted write
    logic permit; // write permit gate
    logic wr_trig; // write trigger
    logic rd_trig; // read trigger
    op_state_type state; // sequencer
    logic [count_width-1:0] count; // self-timed counter
    logic [7:0] rdata; // read data
    logic mem_read; // read strobe to array
    logic mem_write; // write active
    logic mem_erase; // erase active
  } state_type;

  state_type s_q;
  state_type s_d;
  logic [7:0] ctrl_view; // assembled control byte
  logic [7:0] stat_view; // assembled status byte

  // compose readback views
  always_comb begin
    ctrl_view = zero_byte;
    ctrl_view[space_bit] = s_q.space_sel;
    ctrl_view[config_bit] = s_q.config_sel;
    ctrl_view[unused_bit] = 1'b0;
    ctrl_view[erase_bit] = s_q.erase_en;
    ctrl_view[error_bit] = s_q.error_flag;
    ctrl_view[permit_bit] = s_q.permit;
    ctrl_view[write_bit] = s_q.wr_trig;
    ctrl_view[read_bit] = s_q.rd_trig;
    stat_view = zero_byte;
    stat_view[write_bit] = (s_q.state == st_write);
    stat_view[erase_bit] = (s_q.state == st_erase);
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.mem_read = 1'b0;
    s_d.rdata = zero_byte;
    // read port, data one cycle later
    if (i_rd) begin
      case (i_addr)
        ctrl_offset: s_d.rdata = ctrl_view;
        stat_offset: s_d.rdata = stat_view;
        default: s_d.rdata = zero_byte; // unmapped reads zero
      endcase
    end
    // read trigger finishes after one cycle
    if (s_q.rd_trig) begin
      s_d.rd_trig = 1'b0;
    end
    // sequencer
    case (s_q.state)
      st_idle: begin
        s_d.count = '0;
      end
      st_write, st_erase: begin
        if (i_abort) begin
          // cut short: flag it, keep selects for tracing
          s_d.error_flag = 1'b1;
          s_d.wr_trig = 1'b0;
          s_d.state = st_idle;
          s_d.mem_write = 1'b0;
          s_d.mem_erase = 1'b0;
        end else if (s_q.count == write_last) begin
          s_d.wr_trig = 1'b0;
          if (s_q.state == st_erase) begin
            s_d.erase_en = 1'b0;
          end
          s_d.state = st_idle;
          s_d.mem_write = 1'b0;
          s_d.mem_erase = 1'b0;
        end else begin
          s_d.count = s_q.count + count_one;
        end
      end
      default: s_d.state = st_idle;
    endcase
    // software write to control register
    if (i_wr && i_addr == ctrl_offset) begin
      if (s_q.state == st_idle) begin
        s_d.space_sel = i_wdata[space_bit];
        s_d.config_sel = i_wdata[config_bit];
        s_d.erase_en = i_wdata[erase_bit];
      end
      // hardware set of error wins over software clear
      if (!(s_q.state != st_idle && i_abort)) begin
        s_d.error_flag = i_wdata[error_bit];
      end
      s_d.permit = i_wdata[permit_bit];
      // trigger set only; zero ignored
      if (i_wdata[write_bit] && s_q.state == st_idle) begin
        if (s_q.permit) begin
          s_d.wr_trig = 1'b1;
          s_d.count = '0;
          s_d.state = (i_wdata[erase_bit] || s_q.erase_en) ? st_erase : st_write;
          s_d.mem_write = !(i_wdata[erase_bit] || s_q.erase_en);
          s_d.mem_erase = i_wdata[erase_bit] || s_q.erase_en;
        end else begin
          s_d.error_flag = 1'b1; // improper write attempt
        end
      end
      // read only for data eeprom, current and written selects both clear
      if (i_wdata[read_bit] && !s_q.space_sel && !s_q.config_sel
          && !i_wdata[space_bit] && !i_wdata[config_bit]) begin
        s_d.rd_trig = 1'b1;
        s_d.mem_read = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
      s_q.state <= st_idle;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign o_rdata = s_q.rdata;
  assign o_mem_read = s_q.mem_read;
  assign o_mem_write = s_q.mem_write;
  assign o_mem_erase = s_q.mem_erase;
  assign o_mem_flash = s_q.space_sel;
  assign o_mem_config = s_q.config_sel;

endmodule

//--- tb/nvm_access_checker.sv
// Purpose: port checks of nvm_access_control
// Assumes: write_cycles of 8
// Notes: bound from tb
`timescale 1ns/1ps
module nvm_access_checker
  import nvm_access_pkg::*;
#(parameter int unsigned write_cycles = 8) (
  input wire logic i_clk, i_srst, i_wr, i_rd, i_abort,
  input wire logic [addr_width-1:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic o_mem_read, o_mem_write, o_mem_erase, o_mem_flash, o_mem_config
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire busy = o_mem_write | o_mem_erase; // self-timed cycle
  wire cwr = i_wr && i_addr == ctrl_offset; // control write
  a_hole_zero: assert property (!o_rdata[unused_bit]) else $error("bit 5 high");
  a_flash_hold: assert property (!cwr |=> $stable(o_mem_flash)) else $error("flash moved");
  a_config_hold: assert property (!cwr |=> $stable(o_mem_config)) else $error("config moved");
  a_read_pulse: assert property (o_mem_read |=> !o_mem_read) else $error("read too long");
  a_read_refused: assert property (cwr && i_wdata[0] && (i_wdata[7] || i_wdata[6]) |=> !o_mem_read)
    else $error("read not refused");
  a_cycle_ends: assert property ($rose(busy) |-> ##[1:9] !busy) else $error("cycle too long");
  a_abort_ends: assert property (busy && i_abort |=> ##[0:1] !busy) else $error("abort ignored");
  a_error_keeps: assert property (busy && i_abort |=> $stable({o_mem_flash, o_mem_config}))
    else $error("select lost");
  c_write: cover property ($fell(o_mem_write));
  c_erase: cover property ($fell(o_mem_erase));
  c_read: cover property (o_mem_read);
endmodule

//--- tb/nvm_array_model.sv
// Purpose: far-side arrays, counts served operations
// Assumes: write and erase are levels, read a pulse
// Notes: holds no data
`timescale 1ns/1ps
module nvm_array_model (
  input wire logic i_clk, i_read, i_write, i_erase,
  output int o_reads = 0, o_writes = 0, o_erases = 0
);
  logic wr_q = 1'b0, er_q = 1'b0; // levels a cycle ago
  always @(posedge i_clk) begin
    wr_q <= i_write;
    er_q <= i_erase;
    if (i_read) o_reads <= o_reads + 1; // read served
    if (wr_q && !i_write) o_writes <= o_writes + 1; // write closed
    if (er_q && !i_erase) o_erases <= o_erases + 1; // row erased
  end
endmodule

//--- tb/tb.sv
// Purpose: directed bench for nvm_access_control
// Assumes: write_cycles set to 8
// Notes: one task per scenario
`timescale 1ns/1ps
module tb;
  import nvm_access_pkg::*;
  logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, i_abort = 0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic o_mem_read, o_mem_write, o_mem_erase, o_mem_flash, o_mem_config;
  int err_count = 0, cmp_count = 0, n_rd, n_wr, n_er;
  nvm_access_control #(.write_cycles(8)) i_dut (.*);
  nvm_array_model i_mem (.i_clk(i_clk), .i_read(o_mem_read), .i_write(o_mem_write), .i_erase(o_mem_erase),
    .o_reads(n_rd), .o_writes(n_wr), .o_erases(n_er));
  initial forever #20 i_clk = ~i_clk;
  task chk(string n, logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] d, logic [1:0] a = 2'h0);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(logic [7:0] e, string n, logic [1:0] a = 2'h0);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(n, e, o_rdata);
  endtask
  task t_select;
    rd(ctrl_reset, "reset");
    wr(8'hE4);
    rd(8'hC4, "ctrl");
    chk("sel", 8'h03, {6'h00, o_mem_flash, o_mem_config});
    rd(8'h00, "unmapped", 2'h2);
    $display("select done");
  endtask
  task t_write;
    wr(8'h04);
    wr(8'h06);
    chk("busy", 8'h01, {7'h00, o_mem_write});
    rd(8'h02, "status", 2'h1);
    wr(8'h04);
    rd(8'h06, "held");
    repeat (12) @(posedge i_clk);
    rd(8'h04, "done");
    wr(8'h16);
    chk("erase", 8'h01, {7'h00, o_mem_erase});
    repeat (12) @(posedge i_clk);
    rd(8'h04, "erased");
    $display("write done");
  endtask
  task t_fault;
    wr(8'h00);
    wr(8'h02);
    chk("gated", 8'h00, {7'h00, o_mem_write});
    rd(8'h08, "improper");
    wr(8'h84);
    wr(8'h86);
    @(posedge i_clk);
    i_abort <= 1'b1;
    @(posedge i_clk);
    i_abort <= 1'b0;
    rd(8'h8C, "aborted");
    $display("fault done");
  endtask
  task t_read;
    wr(8'h81);
    chk("refused", 8'h00, {7'h00, o_mem_read});
    wr(8'h00);
    wr(8'h01);
    chk("pulse", 8'h01, {7'h00, o_mem_read});
    rd(8'h00, "cleared");
    chk("ops", 8'h51, {n_rd[1:0], n_wr[2:0], n_er[2:0]});
    $display("read done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    t_select;
    t_write;
    t_fault;
    t_read;
    tally_and_finish;
  end
  initial begin
    #20000;
    err_count++;
    tally_and_finish;
  end
endmodule
bind nvm_access_control nvm_access_checker #(.write_cycles(write_cycles)) i_chk (.*);
